//--- rtl/tlvic_flag_cell.sv
`timescale 1ns/1ps
`default_nettype none
module tlvic_flag_cell (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic set,
    input  wire logic clr,
    output var  logic flag
);
    logic flag_ff;

    // set beats clear so an event in the clearing cycle survives
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flag_ff <= 1'b0;
        end else if (set) begin
            flag_ff <= 1'b1;
        end else if (clr) begin
            flag_ff <= 1'b0;
        end
    end

    assign flag = flag_ff;
endmodule
`default_nettype wire

//--- rtl/tlvic_pkg.sv
package tlvic_pkg;

    // source slots are indexed by query order minus one
    localparam int NUM_SLOTS   = 20;
    localparam int NUM_FLAGS   = 21;
    localparam int TX_FLAG_IDX = 20;
    localparam int UART_SLOT   = 4;
    localparam int ADC_SLOT    = 6;
    localparam int INT2_SLOT   = 10;
    localparam int IDX_W       = 5;

    localparam int APB_AW = 12;

    // register byte addresses
    localparam logic [11:0] OFS_IE_MAIN = 12'h0A8;
    localparam logic [11:0] OFS_IE_EXT  = 12'h0AC;
    localparam logic [11:0] OFS_PRIO    = 12'h0B0;
    localparam logic [11:0] OFS_FLAGS   = 12'h0B4;
    localparam logic [11:0] OFS_STATUS  = 12'h0B8;

    localparam int IE_EXT_W = 13;

    localparam logic [7:0]          IE_MAIN_RST = 8'h00;
    localparam logic [IE_EXT_W-1:0] IE_EXT_RST  = 13'h0000;
    localparam logic [19:0]         PRIO_RST    = 20'h00000;

    localparam int GLOBAL_EN_BIT = 7;
    localparam int MAIN_EN_W     = 7;

    // status register fields
    localparam int STAT_ACT_LO  = 0;
    localparam int STAT_ACT_HI  = 1;
    localparam int STAT_REQ     = 2;
    localparam int STAT_HOLD    = 3;
    localparam int STAT_IDX_LSB = 8;
    localparam int STAT_VEC_LSB = 16;

    // vector = base + step * slot
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int          VEC_SHIFT = 3;

    // slot masks: query 12 has no source
    localparam logic [19:0] VALID_MASK    = 20'hFF7FF;
    localparam logic [19:0] AUTO_CLR_MASK = 20'h0060F;
    localparam logic [19:0] WAKE_MASK     = 20'h01605;
    localparam logic [20:0] SW_CLR_MASK   = 21'h1FF1F0;
    localparam logic [20:0] FLAG_VIS_MASK = 21'h1FFBFF;

    typedef struct packed {
        logic ack;
        logic return_from_interrupt;
        logic instr_done;
        logic stop_mode;
    } tlvic_core_in_t;

    typedef struct packed {
        logic        req;
        logic [15:0] vector;
        logic        wake;
    } tlvic_core_out_t;

    typedef struct packed {
        logic [19:0] evt;
        logic        tx_evt;
        logic        conv_start;
    } tlvic_src_t;

endpackage

//--- rtl/tlvic_top.sv
// Contract
// - pulse unit vectors 0043H, query 9, software clears, no stop wake.
// - base timer vectors 004BH, query 10, hardware clears, wakes stop.
// - external 2 vectors 0053H, query 11, no visible flag, wakes stop.
// - comparator vectors 0063H, query 13, software clears, wakes stop.
// - timer 3 at 006BH, timer 4 at 0073H, software clears, no wake.
// - serial units 1-5 vector 007BH..009BH, queries 16-20, software clears.
// - timer 0 and 1 flags set on overflow, cleared on acceptance.
// - timer 2 flag set on overflow, only software clears it.
// - serial port receive/transmit flags set per frame, software clears.
// - conversion start clears converter flag, completion sets it.
// - serial unit done flag set per frame, software clears it.
// - pulse flag set past period, interrupts only when enabled.
// - external 0 and 1 flags hardware cleared; externals 0-2 wake stop.
// - two levels; high preempts low, never same or lower level.
// - after return, one instruction runs before the next acceptance.
// - among equal-level requests the smallest query number wins.
// - acceptance loads vector address; core pushes and pops the counter.
// - same-level request during service stays pending until return.
// - request needs both global enable and its own enable.
// - main enable register at A8H, bit 7 global; zero blocks all.
// - main enable bits 6..0 select sources; all reset to zero.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module tlvic_top (
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [tlvic_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output var  logic [31:0]                prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    input  wire tlvic_pkg::tlvic_src_t      src,
    input  wire tlvic_pkg::tlvic_core_in_t  core_in,
    output var  tlvic_pkg::tlvic_core_out_t core_out
);
    import tlvic_pkg::*;

    logic [7:0]           ie_main_ff;
    logic [IE_EXT_W-1:0]  ie_ext_ff;
    logic [19:0]          prio_ff;
    logic [31:0]          prdata_ff;
    logic                 req_ff;
    logic [15:0]          vector_ff;
    logic [IDX_W-1:0]     gidx_ff;
    logic                 glvl_ff;
    logic                 active_hi_ff;
    logic                 active_lo_ff;
    logic                 hold_ff;
    logic                 wake_ff;

    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flag_clr;
    logic [NUM_FLAGS-1:0] sw_clr;
    logic [19:0]          pend;
    logic [19:0]          en;
    logic [19:0]          cand;
    logic [19:0]          hi_cand;
    logic [19:0]          lo_cand;
    logic [19:0]          pick;
    logic [IDX_W-1:0]     pick_idx;
    logic [31:0]          wmask;
    logic [31:0]          rd_word;
    logic                 rd_hit;
    logic                 acc;
    logic                 wr;
    logic                 accept;

    function automatic logic [IDX_W-1:0] first_set(input logic [19:0] v);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IDX_W'(i);
            end
        end
        return r;
    endfunction

    // ---- APB slave: zero wait states, read data captured in setup phase
    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    assign pready  = acc;
    assign pslverr = acc & ~rd_hit;
    assign prdata  = prdata_ff;
    assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}},
                      {8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (paddr)
            OFS_IE_MAIN: rd_word[7:0] = ie_main_ff;
            OFS_IE_EXT:  rd_word[IE_EXT_W-1:0] = ie_ext_ff;
            OFS_PRIO:    rd_word[19:0] = prio_ff & VALID_MASK;
            // external 2 keeps a hidden pending bit, never shown
            OFS_FLAGS:   rd_word[NUM_FLAGS-1:0] = flags & FLAG_VIS_MASK;
            OFS_STATUS: begin
                rd_word[STAT_ACT_LO] = active_lo_ff;
                rd_word[STAT_ACT_HI] = active_hi_ff;
                rd_word[STAT_REQ]    = req_ff;
                rd_word[STAT_HOLD]   = hold_ff;
                rd_word[STAT_IDX_LSB +: IDX_W] = gidx_ff;
                rd_word[STAT_VEC_LSB +: 16]    = vector_ff;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_ff <= rd_word;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ie_main_ff <= IE_MAIN_RST;
        end else if (wr && paddr == OFS_IE_MAIN) begin
            ie_main_ff <= (ie_main_ff & ~wmask[7:0])
                        | (pwdata[7:0] & wmask[7:0]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ie_ext_ff <= IE_EXT_RST;
        end else if (wr && paddr == OFS_IE_EXT) begin
            ie_ext_ff <= (ie_ext_ff & ~wmask[IE_EXT_W-1:0])
                       | (pwdata[IE_EXT_W-1:0] & wmask[IE_EXT_W-1:0]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prio_ff <= PRIO_RST;
        end else if (wr && paddr == OFS_PRIO) begin
            prio_ff <= ((prio_ff & ~wmask[19:0])
                     | (pwdata[19:0] & wmask[19:0])) & VALID_MASK;
        end
    end

    assign sw_clr = (wr && paddr == OFS_FLAGS)
                  ? (pwdata[NUM_FLAGS-1:0] & wmask[NUM_FLAGS-1:0]
                     & SW_CLR_MASK)
                  : '0;

    // ---- flags
    assign accept = core_in.ack & req_ff;

    always_comb begin
        flag_set = {src.tx_evt, src.evt & VALID_MASK};
        flag_clr = sw_clr;
        if (accept && AUTO_CLR_MASK[gidx_ff]) begin
            flag_clr[gidx_ff] = 1'b1;
        end
        if (src.conv_start) begin
            flag_clr[ADC_SLOT] = 1'b1;
        end
    end

    for (genvar g = 0; g < NUM_FLAGS; g++) begin : g_flag
        tlvic_flag_cell u_cell (
            .ref_clk (ref_clk),
            .rst     (rst),
            .set     (flag_set[g]),
            .clr     (flag_clr[g]),
            .flag    (flags[g])
        );
    end

    always_comb begin
        pend = flags[NUM_SLOTS-1:0] & VALID_MASK;
        // serial port slot requests on either direction
        pend[UART_SLOT] = flags[UART_SLOT] | flags[TX_FLAG_IDX];
    end

    // own enable and global enable both needed
    assign en   = {ie_ext_ff, ie_main_ff[MAIN_EN_W-1:0]} & VALID_MASK;
    assign cand = pend & en & {NUM_SLOTS{ie_main_ff[GLOBAL_EN_BIT]}};

    // level gating against routines in service
    assign hi_cand = cand & prio_ff & {NUM_SLOTS{~active_hi_ff}};
    assign lo_cand = cand & ~prio_ff
                   & {NUM_SLOTS{~active_hi_ff & ~active_lo_ff}};
    assign pick    = (|hi_cand) ? hi_cand : lo_cand;

    assign pick_idx = first_set(pick);

    // block acceptance between a return and the next instruction
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hold_ff <= 1'b0;
        end else if (core_in.return_from_interrupt) begin
            hold_ff <= 1'b1;
        end else if (core_in.instr_done) begin
            hold_ff <= 1'b0;
        end
    end

    // request withdrawn for a cycle on acceptance and on return
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_ff  <= 1'b0;
            gidx_ff <= '0;
            glvl_ff <= 1'b0;
        end else begin
            req_ff  <= (|pick) & ~hold_ff & ~accept & ~core_in.return_from_interrupt;
            gidx_ff <= pick_idx;
            glvl_ff <= |hi_cand;
        end
    end

    // vector = 0003H + 8 * slot
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            vector_ff <= VEC_BASE;
        end else begin
            vector_ff <= VEC_BASE + (16'(pick_idx) << VEC_SHIFT);
        end
    end

    // in-service levels; return ends the highest one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            active_hi_ff <= 1'b0;
            active_lo_ff <= 1'b0;
        end else if (accept) begin
            if (glvl_ff) begin
                active_hi_ff <= 1'b1;
            end else begin
                active_lo_ff <= 1'b1;
            end
        end else if (core_in.return_from_interrupt) begin
            if (active_hi_ff) begin
                active_hi_ff <= 1'b0;
            end else begin
                active_lo_ff <= 1'b0;
            end
        end
    end

    // stop wake ignores global enable and level state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= core_in.stop_mode & (|(pend & en & WAKE_MASK));
        end
    end

    assign core_out.req    = req_ff;
    assign core_out.vector = vector_ff;
    assign core_out.wake   = wake_ff;
endmodule
`default_nettype wire

//--- testbench/tb_two_level_vectored_irq_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_two_level_vectored_irq_controller;
    import tlvic_pkg::*;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic hold, slow, stop, e, auto_clr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb;
    tlvic_src_t src;
    tlvic_core_in_t core_in;
    tlvic_core_out_t core_out;
    int bad_count, check_count;
    logic [15:0] got_q [0:31];
    int          got_n;
    int          got_i;
    tlvic_top dut_u (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .src, .core_in,
        .core_out);
    tlvic_core_model core_u (.ref_clk, .rst, .hold, .slow, .stop,
        .core_out, .core_in);
    // the core may accept while a bus call runs, so log every acceptance
    always @(posedge ref_clk) begin
        if (core_in.ack === 1'h1 && core_out.req === 1'h1) begin
            got_q[got_n[4:0]] <= core_out.vector;
            got_n <= got_n + 1;
        end
    end
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        @(posedge ref_clk);
        while (pready !== 1'h1) @(posedge ref_clk);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        cmp(r, exp);
    endtask
    task automatic pulse(input logic [19:0] v, input logic t, input logic c);
        @(posedge ref_clk);
        src <= {v, t, c};
        @(posedge ref_clk);
        src <= '0;
    endtask
    task automatic acc(input logic [15:0] v);
        int n;
        n = 0;
        while (got_n <= got_i && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        cmp({15'h0, got_n > got_i, got_q[got_i[4:0]]}, {16'h1, v});
        got_i++;
    endtask
    task automatic rel();
        @(posedge ref_clk);
        hold <= 1'h0;
        repeat (3) @(posedge ref_clk);
        hold <= 1'h1;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        complete_run();
    end
    initial begin
        {rst, hold} = 2'h3;
        {psel, penable, pwrite, slow, stop} = '0;
        {paddr, pwdata, src} = '0;
        pstrb = 4'hF;
        repeat (3) @(posedge ref_clk);
        rst <= 1'h0;
        rdc(OFS_IE_MAIN, 32'h0);
        apb(1'h0, 12'h0A0, 32'h0);
        cmp({31'h0, e}, 32'h1);
        wr(OFS_IE_EXT, 32'h1FFF);
        wr(OFS_IE_MAIN, 32'h7F);
        pulse(20'h2, 1'h1, 1'h0);
        repeat (4) @(negedge ref_clk);
        cmp({31'h0, core_out.req}, 32'h0);
        rdc(OFS_FLAGS, 32'h100002);
        wr(OFS_IE_MAIN, 32'hFF);
        rdc(OFS_IE_MAIN, 32'hFF);
        acc(16'h000B);
        rdc(OFS_FLAGS, 32'h100000);
        wr(OFS_FLAGS, 32'h1FFFFF);
        rel();
        wr(OFS_IE_MAIN, 32'hBF);
        wr(OFS_IE_EXT, 32'h0);
        pulse(20'h140, 1'h0, 1'h0);
        repeat (4) @(negedge ref_clk);
        cmp({31'h0, core_out.req}, 32'h0);
        rdc(OFS_FLAGS, 32'h140);
        pulse(20'h0, 1'h0, 1'h1);
        rdc(OFS_FLAGS, 32'h100);
        wr(OFS_FLAGS, 32'h1FFFFF);
        wr(OFS_IE_MAIN, 32'hFF);
        wr(OFS_IE_EXT, 32'h1FFF);
        for (int i = 0; i < 20; i++) begin
            if (i != 11) begin
                pulse(20'h1 << i, 1'h0, 1'h0);
                acc(16'h0003 + 16'(i * 8));
                auto_clr = i < 4 || i == 9 || i == 10;
                rdc(OFS_FLAGS, auto_clr ? 32'h0 : 32'h1 << i);
                wr(OFS_FLAGS, 32'h1FFFFF);
                rel();
            end
        end
        slow <= 1'h1;
        wr(OFS_PRIO, 32'h20);
        pulse(20'hA, 1'h0, 1'h0);
        acc(16'h000B);
        repeat (6) @(negedge ref_clk);
        cmp({31'h0, core_out.req}, 32'h0);
        pulse(20'h20, 1'h0, 1'h0);
        acc(16'h002B);
        wr(OFS_FLAGS, 32'h20);
        rel();
        acc(16'h001B);
        rel();
        wr(OFS_IE_MAIN, 32'h7F);
        stop <= 1'h1;
        pulse(20'h2000, 1'h0, 1'h0);
        repeat (4) @(negedge ref_clk);
        cmp({31'h0, core_out.wake}, 32'h0);
        pulse(20'h200, 1'h0, 1'h0);
        repeat (4) @(negedge ref_clk);
        cmp({31'h0, core_out.wake}, 32'h1);
        cmp(32'(got_n), 32'(got_i));
        complete_run();
    end
endmodule
`default_nettype wire

//--- testbench/tlvic_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tlvic_asserts (
    input wire logic                        ref_clk,
    input wire logic                        rst,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [tlvic_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire tlvic_pkg::tlvic_src_t       src,
    input wire tlvic_pkg::tlvic_core_in_t   core_in,
    input wire tlvic_pkg::tlvic_core_out_t  core_out
);
    import tlvic_pkg::*;
    logic       ea_ff;
    logic       gap_ff;
    logic [1:0] dep_ff;
    logic       ea_wr;
    logic       map_w;
    logic       acc_w;
    assign ea_wr = psel && penable && pwrite && pstrb[0]
                && paddr == OFS_IE_MAIN;
    assign map_w = paddr inside {OFS_IE_MAIN, OFS_IE_EXT, OFS_PRIO,
                                 OFS_FLAGS, OFS_STATUS};
    assign acc_w = core_in.ack && core_out.req;
    // shadow of the global enable, seen only from bus writes
    always_ff @(posedge ref_clk) begin
        ea_ff <= rst ? 1'h0 : (ea_wr ? pwdata[7] : ea_ff);
    end
    always_ff @(posedge ref_clk) begin
        gap_ff <= rst ? 1'h0 : core_in.return_from_interrupt ? 1'h1
                : core_in.instr_done ? 1'h0 : gap_ff;
    end
    always_ff @(posedge ref_clk) begin
        dep_ff <= rst ? 2'h0 : acc_w ? dep_ff + 2'h1
                : (core_in.return_from_interrupt && dep_ff != 2'h0) ? dep_ff - 2'h1 : dep_ff;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ready_zero_a: assert property (pready == (psel && penable))
        else $error("pready outside access phase");
    unmapped_err_a: assert property (psel && penable |-> pslverr == !map_w)
        else $error("pslverr does not match decode");
    vec_step_a: assert property (core_out.req |-> core_out.vector[2:0] == 3'h3)
        else $error("vector not on an eight byte step");
    vec_span_a: assert property (core_out.req |-> core_out.vector <= 16'h009B)
        else $error("vector above last source");
    vec_hole_a: assert property (core_out.req |-> core_out.vector != 16'h005B)
        else $error("vector of the empty slot");
    ea_block_a: assert property (!ea_ff && $past(!ea_ff) |-> !core_out.req)
        else $error("request with global enable off");
    ack_drop_a: assert property (acc_w |=> !core_out.req)
        else $error("request kept after acceptance");
    ret_gap_a: assert property (gap_ff |-> !core_out.req)
        else $error("request before an instruction after return");
    nest_max_a: assert property (dep_ff == 2'h2 |-> !core_out.req)
        else $error("request while high level in service");
endmodule
bind tlvic_top tlvic_asserts u_chk (.ref_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .src, .core_in,
    .core_out);
`default_nettype wire

//--- testbench/tlvic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module tlvic_core_model (
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire logic                       hold,
    input  wire logic                       slow,
    input  wire logic                       stop,
    input  wire tlvic_pkg::tlvic_core_out_t core_out,
    output var  tlvic_pkg::tlvic_core_in_t  core_in
);
    import tlvic_pkg::*;
    logic [1:0] dep_ff;
    logic [1:0] wait_ff;
    logic       go;
    logic       take;
    logic       ret;
    // one decision per cycle, so every output is written once an edge
    assign go   = !slow || wait_ff == 2'h3;
    assign take = core_out.req && !core_in.ack;
    assign ret  = !take && dep_ff != 2'h0 && !hold && !core_in.return_from_interrupt;
    always_ff @(posedge ref_clk) begin
        core_in.stop_mode  <= stop;
        core_in.ack        <= !rst && take && go;
        core_in.return_from_interrupt       <= !rst && ret;
        // slow mode delays the next instruction
        core_in.instr_done <= !rst && !take && !ret && go;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dep_ff <= 2'h0;
        end else if (take && go) begin
            dep_ff <= dep_ff + 2'h1;
        end else if (ret) begin
            dep_ff <= dep_ff - 2'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst || ret || (take && go)) begin
            wait_ff <= 2'h0;
        end else begin
            wait_ff <= wait_ff + 2'h1;
        end
    end
endmodule
`default_nettype wire
